/* hdl/vroc_defines.svh */
// constants for the voltage restrained overcurrent block
`ifndef VROC_DEFINES_SVH
`define VROC_DEFINES_SVH
// ============================================================
// register byte offsets
`define ADDR_CTRL 12'h000
`define ADDR_OC_LEVEL 12'h004
`define ADDR_OC_DELAY 12'h008
`define ADDR_TMULT 12'h00C
`define ADDR_MIN_TIME 12'h010
`define ADDR_UV_LEVEL 12'h014
`define ADDR_UV_DELAY 12'h018
`define ADDR_LVB_LEVEL 12'h01C
`define ADDR_VDEP 12'h020
`define ADDR_BASE 12'h024
`define ADDR_STATUS 12'h028
`define ADDR_MEAS 12'h02C
// ============================================================
// control fields
`define CTRL_OP_BIT 0
`define CTRL_UV_EN_BIT 1
`define CTRL_LVB_EN_BIT 2
`define CTRL_MODE_BIT 3
`define CTRL_CHAR_BIT 4
`define CTRL_SEAL_BIT 5
// ============================================================
// reset values
`define RST_CTRL 32'h0000_0000
`define RST_OC_LEVEL 16'd150
`define RST_OC_DELAY 32'h0000_0000
`define RST_TMULT 16'd100
`define RST_MIN_TIME 32'd50
`define RST_UV_LEVEL 16'd70
`define RST_UV_DELAY 32'd3000
`define RST_LVB_LEVEL 16'd10
`define RST_VDEP_FACT 16'd25
`define RST_UHIGH 16'd100
`define RST_BASE 16'd1000
// ============================================================
// timing: delays in ms, tick is 1 ms at 100 MHz
`define CLK_HZ 100000000
`define TICK_CYCLES (`CLK_HZ / 1000)
`define SEAL_BLOCK_MS 2000
`define QUARTER_PCT 16'd25
`endif

/* hdl/vroc_pkg.sv */
// types for the voltage restrained overcurrent block
`default_nettype none
package vroc_pkg;
    typedef struct packed {
        logic [15:0] l1;
        logic [15:0] l2;
        logic [15:0] l3;
    } phase3_t;
    typedef struct packed {
        logic start;
        logic trip;
    } stage_out_t;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_TIMING = 4'b0010,
        ST_TRIP = 4'b0100,
        ST_BLOCK = 4'b1000
    } seal_state_t;
endpackage
`default_nettype wire

/* hdl/stage_timer.sv */
// delay timer for one protection stage
`default_nettype none
module stage_timer #(
    parameter int WIDTH = 32
) (
    // clock
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic tick,
    // control
    input wire logic start,
    input wire logic [WIDTH-1:0] delay,
    // result
    output logic trip
);
    logic [WIDTH-1:0] count_r;
    // ============================================================
    // count ms while start holds
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_r <= '0;
        end else if (ce) begin
            if (!start) begin
                count_r <= '0;
            end else if (tick && count_r < delay) begin
                count_r <= count_r + 1'b1;
            end
        end
    end
    assign trip = start && (count_r >= delay);
endmodule
`default_nettype wire

/* hdl/vroc_top.sv */
// voltage restrained overcurrent function with axi4-lite settings
//
// Local design decisions: the AXI4-Lite slave port and the register addresses.
`include "vroc_defines.svh"
`default_nettype none
module vroc_top #(
    parameter int TICK = `TICK_CYCLES,
    parameter int SEAL_MS = `SEAL_BLOCK_MS
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // measurements, in the units of the base current and voltage settings
    input wire vroc_pkg::phase3_t phase_current,
    input wire vroc_pkg::phase3_t phase_voltage,
    // axi4-lite write
    input wire logic [11:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    // axi4-lite read
    input wire logic [11:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // protection outputs
    output vroc_pkg::stage_out_t oc_out,
    output vroc_pkg::stage_out_t uv_out,
    output logic seal_trip
);
    import vroc_pkg::*;

    function automatic logic [15:0] max3(input phase3_t p);
        logic [15:0] m;
        m = (p.l1 > p.l2) ? p.l1 : p.l2;
        return (m > p.l3) ? m : p.l3;
    endfunction
    function automatic logic [15:0] min3(input phase3_t p);
        logic [15:0] m;
        m = (p.l1 < p.l2) ? p.l1 : p.l2;
        return (m < p.l3) ? m : p.l3;
    endfunction
    function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
                                           input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // ============================================================
    // settings registers
    logic [31:0] ctrl_r, oc_delay_r, min_time_r, uv_delay_r;
    logic [15:0] oc_level_r, tmult_r, uv_level_r, lvb_level_r, vdep_fact_r, uhigh_r;
    logic [15:0] base_current_r, base_voltage_r;
    logic aw_have_r, w_have_r;
    logic [11:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic op_en, uv_en, lvb_en, mode_step, char_inv, seal_en;
    assign op_en = ctrl_r[`CTRL_OP_BIT];
    assign uv_en = ctrl_r[`CTRL_UV_EN_BIT];
    assign lvb_en = ctrl_r[`CTRL_LVB_EN_BIT];
    assign mode_step = ctrl_r[`CTRL_MODE_BIT];
    assign char_inv = ctrl_r[`CTRL_CHAR_BIT];
    assign seal_en = ctrl_r[`CTRL_SEAL_BIT];

    // ============================================================
    // axi write channel
    logic do_write;
    assign s_awready = !aw_have_r && !s_bvalid;
    assign s_wready = !w_have_r && !s_bvalid;
    assign do_write = aw_have_r && w_have_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            awaddr_r <= '0;
            wdata_r <= '0;
            wstrb_r <= '0;
            s_bvalid <= 1'b0;
            s_bresp <= 2'b00;
        end else if (ce) begin
            if (s_awvalid && s_awready) begin
                aw_have_r <= 1'b1;
                awaddr_r <= s_awaddr;
            end
            if (s_wvalid && s_wready) begin
                w_have_r <= 1'b1;
                wdata_r <= s_wdata;
                wstrb_r <= s_wstrb;
            end
            if (do_write) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                s_bvalid <= 1'b1;
                s_bresp <= (awaddr_r > `ADDR_VDEP && awaddr_r != `ADDR_BASE) ? 2'b10 : 2'b00;
            end else if (s_bvalid && s_bready) begin
                s_bvalid <= 1'b0;
            end
        end
    end

    // ============================================================
    // register updates
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= `RST_CTRL;
            oc_level_r <= `RST_OC_LEVEL;
            oc_delay_r <= `RST_OC_DELAY;
            tmult_r <= `RST_TMULT;
            min_time_r <= `RST_MIN_TIME;
            uv_level_r <= `RST_UV_LEVEL;
            uv_delay_r <= `RST_UV_DELAY;
            lvb_level_r <= `RST_LVB_LEVEL;
            vdep_fact_r <= `RST_VDEP_FACT;
            uhigh_r <= `RST_UHIGH;
            base_current_r <= `RST_BASE;
            base_voltage_r <= `RST_BASE;
        end else if (ce && do_write) begin
            case (awaddr_r)
                `ADDR_CTRL: ctrl_r <= wmerge(ctrl_r, wdata_r, wstrb_r);
                `ADDR_OC_LEVEL: oc_level_r <= 16'(wmerge({16'h0, oc_level_r}, wdata_r, wstrb_r));
                `ADDR_OC_DELAY: oc_delay_r <= wmerge(oc_delay_r, wdata_r, wstrb_r);
                `ADDR_TMULT: tmult_r <= 16'(wmerge({16'h0, tmult_r}, wdata_r, wstrb_r));
                `ADDR_MIN_TIME: min_time_r <= wmerge(min_time_r, wdata_r, wstrb_r);
                `ADDR_UV_LEVEL: uv_level_r <= 16'(wmerge({16'h0, uv_level_r}, wdata_r, wstrb_r));
                `ADDR_UV_DELAY: uv_delay_r <= wmerge(uv_delay_r, wdata_r, wstrb_r);
                `ADDR_LVB_LEVEL: lvb_level_r <= 16'(wmerge({16'h0, lvb_level_r}, wdata_r, wstrb_r));
                `ADDR_VDEP: begin
                    {uhigh_r, vdep_fact_r} <= wmerge({uhigh_r, vdep_fact_r}, wdata_r, wstrb_r);
                end
                `ADDR_BASE: begin
                    {base_voltage_r, base_current_r} <=
                        wmerge({base_voltage_r, base_current_r}, wdata_r, wstrb_r);
                end
                default: ;
            endcase
        end
    end

    // ============================================================
    // measurements and start levels
    logic [15:0] i_max_r, u_min_r;
    logic [31:0] i_pct, u_pct;
    logic [31:0] lvl_full, lvl_low, lvl_eff;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            i_max_r <= '0;
            u_min_r <= '0;
        end else if (ce) begin
            i_max_r <= max3(phase_current);
            u_min_r <= min3(phase_voltage);
        end
    end
    // per mille of base scaled to percent*10 of base setting
    assign i_pct = (32'(i_max_r) * 32'd1000) / {16'h0, (base_current_r == 0) ? 16'd1 : base_current_r};
    assign u_pct = (32'(u_min_r) * 32'd1000) / {16'h0, (base_voltage_r == 0) ? 16'd1 : base_voltage_r};
    assign lvl_full = 32'(oc_level_r) * 32'd10;
    assign lvl_low = (lvl_full * 32'(vdep_fact_r)) / 32'd100;
    always_comb begin
        lvl_eff = lvl_full;
        if (!mode_step) begin
            if (u_pct < 32'(`QUARTER_PCT) * 32'd10) begin
                lvl_eff = lvl_low;
            end else if (u_pct < 32'(uhigh_r) * 32'd10 && uhigh_r > `QUARTER_PCT) begin
                lvl_eff = lvl_low + ((lvl_full - lvl_low) * (u_pct - 32'd250)) /
                          (32'(uhigh_r) * 32'd10 - 32'd250);
            end
        end else if (u_pct < 32'(uhigh_r) * 32'd10) begin
            lvl_eff = lvl_low;
        end
    end

    // ============================================================
    // ms tick
    logic [31:0] tick_cnt_r;
    logic tick;
    assign tick = (tick_cnt_r == 32'(TICK - 1));
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_cnt_r <= '0;
        end else if (ce) begin
            tick_cnt_r <= tick ? '0 : tick_cnt_r + 1'b1;
        end
    end

    // ============================================================
    // overcurrent stage
    logic oc_start, oc_trip_raw, blocked;
    logic [31:0] inv_time, oc_delay;
    assign oc_start = op_en && !blocked && (i_pct >= lvl_eff);
    // simplified inverse: time = k * level / (i - level) seconds scaled to ms
    always_comb begin
        inv_time = (i_pct > lvl_eff) ?
            (32'(tmult_r) * 32'd10 * lvl_eff) / (i_pct - lvl_eff) : 32'hFFFF;
        if (inv_time < min_time_r) begin
            inv_time = min_time_r;
        end
        oc_delay = char_inv ? inv_time + oc_delay_r : oc_delay_r;
    end
    stage_timer #(.WIDTH(32)) oc_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .tick(tick),
        .start(oc_start),
        .delay(oc_delay),
        .trip(oc_trip_raw)
    );

    // ============================================================
    // undervoltage stage
    logic uv_start, uv_trip_raw, lv_block;
    assign lv_block = lvb_en && (u_pct < 32'(lvb_level_r) * 32'd10);
    assign uv_start = op_en && uv_en && !blocked && !lv_block && (!seal_en || oc_start) &&
                      (u_pct < 32'(uv_level_r) * 32'd10);
    stage_timer #(.WIDTH(32)) uv_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .tick(tick),
        .start(uv_start),
        .delay(uv_delay_r),
        .trip(uv_trip_raw)
    );

    // ============================================================
    // seal-in block after trip
    seal_state_t seal_r;
    logic [31:0] seal_cnt_r;
    assign blocked = (seal_r == ST_BLOCK);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            seal_r <= ST_IDLE;
            seal_cnt_r <= '0;
        end else if (ce) begin
            case (seal_r)
                ST_IDLE: begin
                    seal_cnt_r <= '0;
                    if (seal_en && op_en && uv_trip_raw) begin
                        seal_r <= ST_TRIP;
                    end
                end
                ST_TRIP: begin
                    if (!op_en || !seal_en) begin
                        seal_r <= ST_IDLE;
                    end else if (tick) begin
                        seal_cnt_r <= seal_cnt_r + 1'b1;
                        if (seal_cnt_r == 32'(SEAL_MS - 1)) begin
                            seal_r <= ST_BLOCK;
                        end
                    end
                end
                ST_BLOCK: begin
                    if (!uv_trip_raw) begin
                        seal_r <= ST_IDLE;
                    end
                end
                default: seal_r <= ST_IDLE;
            endcase
        end
    end

    // ============================================================
    // registered outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            oc_out <= '0;
            uv_out <= '0;
            seal_trip <= 1'b0;
        end else if (ce) begin
            oc_out <= '{start: oc_start, trip: oc_trip_raw && op_en};
            uv_out <= '{start: uv_start, trip: uv_trip_raw && op_en};
            seal_trip <= seal_r == ST_TRIP;
        end
    end

    // ============================================================
    // axi read channel
    assign s_arready = !s_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_rvalid <= 1'b0;
            s_rdata <= '0;
            s_rresp <= 2'b00;
        end else if (ce) begin
            if (s_arvalid && s_arready) begin
                s_rvalid <= 1'b1;
                s_rresp <= 2'b00;
                case (s_araddr)
                    `ADDR_CTRL: s_rdata <= ctrl_r;
                    `ADDR_OC_LEVEL: s_rdata <= {16'h0, oc_level_r};
                    `ADDR_OC_DELAY: s_rdata <= oc_delay_r;
                    `ADDR_TMULT: s_rdata <= {16'h0, tmult_r};
                    `ADDR_MIN_TIME: s_rdata <= min_time_r;
                    `ADDR_UV_LEVEL: s_rdata <= {16'h0, uv_level_r};
                    `ADDR_UV_DELAY: s_rdata <= uv_delay_r;
                    `ADDR_LVB_LEVEL: s_rdata <= {16'h0, lvb_level_r};
                    `ADDR_VDEP: s_rdata <= {uhigh_r, vdep_fact_r};
                    `ADDR_BASE: s_rdata <= {base_voltage_r, base_current_r};
                    `ADDR_STATUS: s_rdata <= {24'h0, seal_r, oc_out.trip, oc_out.start,
                                              uv_out.trip, uv_out.start};
                    `ADDR_MEAS: s_rdata <= {u_min_r, i_max_r};
                    default: begin
                        s_rdata <= '0;
                        s_rresp <= 2'b10;
                    end
                endcase
            end else if (s_rvalid && s_rready) begin
                s_rvalid <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

/* tb/vroc_top_monitor.sv */
// assertion checker for the voltage restrained overcurrent ports
`default_nettype none
module vroc_top_monitor #(
    parameter int TICK = 100000,
    parameter int SEAL_MS = 2000
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // measurements
    input wire vroc_pkg::phase3_t phase_current,
    // bus handshakes
    input wire logic s_awvalid,
    input wire logic s_awready,
    input wire logic s_wvalid,
    input wire logic s_wready,
    input wire logic s_bvalid,
    input wire logic s_arvalid,
    input wire logic s_arready,
    input wire logic s_rvalid,
    // protection outputs
    input wire vroc_pkg::stage_out_t oc_out,
    input wire vroc_pkg::stage_out_t uv_out,
    input wire logic seal_trip
);
    import vroc_pkg::*;
    localparam int SEAL_SPAN = SEAL_MS * TICK + 4;
    logic no_current;
    logic [31:0] seal_cnt_r;
    // ============================================================
    // helper logic
    assign no_current = (phase_current == 48'h0000_0000_0000);
    always_ff @(posedge aclk) begin
        if (!aresetn || !seal_trip) begin
            seal_cnt_r <= 32'h0000_0000;
        end else begin
            seal_cnt_r <= seal_cnt_r + 32'h0000_0001;
        end
    end
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // ============================================================
    // assertions
    a_reset_quiet: assert property (disable iff (1'b0)
        !aresetn |=> !oc_out.start && !uv_out.start && !seal_trip)
        else $error("outputs active after reset");
    a_oc_trip_start: assert property (oc_out.trip |-> oc_out.start)
        else $error("overcurrent trip without start");
    a_uv_trip_start: assert property (uv_out.trip |-> uv_out.start)
        else $error("undervoltage trip without start");
    a_oc_no_current: assert property (no_current [*3] |-> !oc_out.start)
        else $error("overcurrent start with zero current");
    a_seal_span: assert property (seal_cnt_r <= 32'(SEAL_SPAN))
        else $error("seal trip state held too long");
    a_seal_from_uv: assert property ($rose(seal_trip) |-> ##[0:1] uv_out.trip)
        else $error("seal trip without undervoltage trip");
    a_read_answer: assert property (s_arvalid && s_arready |=> s_rvalid)
        else $error("read answer late");
    a_write_answer: assert property (
        s_awvalid && s_awready && s_wvalid && s_wready |-> ##[1:2] s_bvalid)
        else $error("write answer late");
    c_oc_trip: cover property (oc_out.trip);
    c_uv_trip: cover property (uv_out.trip);
    c_seal_end: cover property ($fell(seal_trip));
endmodule
`default_nettype wire

/* tb/meas_source.sv */
// upstream phase measurement model
`default_nettype none
module meas_source (
    // clock
    input wire logic aclk,
    // wanted extremes
    input wire logic [15:0] i_peak,
    input wire logic [15:0] u_low,
    input wire logic [1:0] sel,
    // phase values
    output var vroc_pkg::phase3_t phase_current,
    output var vroc_pkg::phase3_t phase_voltage
);
    timeunit 1ns;
    timeprecision 1ps;
    import vroc_pkg::*;
    // extreme phase moves with sel, others milder
    always_ff @(posedge aclk) begin
        phase_current.l1 <= (sel == 2'h0) ? i_peak : i_peak >> 1;
        phase_current.l2 <= (sel == 2'h1) ? i_peak : i_peak >> 2;
        phase_current.l3 <= (sel == 2'h2) ? i_peak : i_peak >> 1;
        phase_voltage.l1 <= (sel == 2'h1) ? u_low : u_low + 16'h0064;
        phase_voltage.l2 <= (sel == 2'h2) ? u_low : u_low + 16'h00C8;
        phase_voltage.l3 <= (sel == 2'h0) ? u_low : u_low + 16'h0064;
    end
endmodule
`default_nettype wire

/* tb/test_voltage_restrained_overcurrent.sv */
// bench for the voltage restrained overcurrent block
`include "vroc_defines.svh"
`default_nettype none
module test_voltage_restrained_overcurrent;
    timeunit 1ns;
    timeprecision 1ps;
    import vroc_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, seen = 1'b0;
    logic [15:0] i_pk = 16'h0000, u_lo = 16'h03E8;
    logic [1:0] sel = 2'h0, s_bresp, s_rresp, rr;
    logic [11:0] s_awaddr = 12'h000, s_araddr = 12'h000;
    logic [31:0] s_wdata = 32'h0000_0000, s_rdata, rv;
    logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
    logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, seal_trip;
    phase3_t phase_current, phase_voltage;
    stage_out_t oc_out, uv_out, so;
    int n_errors = 0, samples_checked = 0;
    logic [31:0] rst_vals [11] = '{32'h0000_0000, 32'h0000_0096, 32'h0000_0000, 32'h0000_0064,
        32'h0000_0032, 32'h0000_0046, 32'h0000_0BB8, 32'h0000_000A, 32'h0064_0019,
        32'h03E8_03E8, 32'h0000_0010};
    // ctrl, voltage, current, stage, expected start
    logic [41:0] rows [16] = '{
        {8'h01, 16'h00C8, 16'h01F4, 1'b0, 1'b1}, {8'h01, 16'h03E8, 16'h01F4, 1'b0, 1'b0},
        {8'h01, 16'h044C, 16'h0578, 1'b0, 1'b0}, {8'h01, 16'h044C, 16'h0640, 1'b0, 1'b1},
        {8'h01, 16'h0271, 16'h0320, 1'b0, 1'b0}, {8'h01, 16'h0271, 16'h044C, 1'b0, 1'b1},
        {8'h09, 16'h0384, 16'h01F4, 1'b0, 1'b1}, {8'h09, 16'h044C, 16'h01F4, 1'b0, 1'b0},
        {8'h09, 16'h00C8, 16'h01F4, 1'b0, 1'b1}, {8'h00, 16'h03E8, 16'h07D0, 1'b0, 1'b0},
        {8'h03, 16'h01F4, 16'h0000, 1'b1, 1'b1}, {8'h03, 16'h0320, 16'h0000, 1'b1, 1'b0},
        {8'h01, 16'h01F4, 16'h0000, 1'b1, 1'b0}, {8'h07, 16'h0032, 16'h0000, 1'b1, 1'b0},
        {8'h07, 16'h01F4, 16'h0000, 1'b1, 1'b1}, {8'h00, 16'h01F4, 16'h0000, 1'b1, 1'b0}};
    // ============================================================
    // design and partner
    vroc_top #(.TICK(10), .SEAL_MS(5)) dut (
        .aclk(aclk), .aresetn(aresetn), .ce(1'b1),
        .phase_current(phase_current), .phase_voltage(phase_voltage),
        .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
        .s_wdata(s_wdata), .s_wstrb(4'hF), .s_wvalid(s_wvalid), .s_wready(s_wready),
        .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
        .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
        .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
        .oc_out(oc_out), .uv_out(uv_out), .seal_trip(seal_trip));
    meas_source u_meas (.aclk(aclk), .i_peak(i_pk), .u_low(u_lo), .sel(sel),
        .phase_current(phase_current), .phase_voltage(phase_voltage));
    initial begin
        forever #5 aclk = ~aclk;
    end
    // ============================================================
    // tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        s_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_awready) s_awvalid <= 1'b0;
            if (s_wready) s_wvalid <= 1'b0;
        end while (!s_bvalid);
        r = s_bresp;
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_arready) s_arvalid <= 1'b0;
        end while (!s_rvalid);
        d = s_rdata;
        r = s_rresp;
    endtask
    task automatic set(input logic [11:0] a, input logic [31:0] d);
        wr(a, d, rr);
        chk({30'h0, rr}, 32'h0000_0000);
    endtask
    task automatic drive(input logic [15:0] i, input logic [15:0] u);
        i_pk <= i;
        u_lo <= u;
    endtask
    function automatic stage_out_t pick(input logic w);
        return w ? uv_out : oc_out;
    endfunction
    task automatic timed(input logic w, input int t);
        tick(8);
        chk({30'h0, pick(w)}, 32'h0000_0002);
        tick(t * 10 - 20);
        chk({30'h0, pick(w)}, 32'h0000_0002);
        tick(30);
        chk({30'h0, pick(w)}, 32'h0000_0003);
    endtask
    task automatic finish_test();
        if (n_errors == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #100000;
        n_errors++;
        finish_test();
    end
    // ============================================================
    // main sequence
    initial begin
        tick(5);
        aresetn <= 1'b1;
        tick(1);
        for (int k = 0; k < 11; k++) begin
            rd(12'(k * 4), rv, rr);
            chk(rv, rst_vals[k]);
        end
        rd(12'h030, rv, rr);
        chk({rv[29:0], rr}, 32'h0000_0002);
        wr(12'h030, 32'hA5A5_A5A5, rr);
        chk({30'h0, rr}, 32'h0000_0002);
        wr(`ADDR_STATUS, 32'hFFFF_FFFF, rr);
        chk({30'h0, rr}, 32'h0000_0002);
        set(`ADDR_LVB_LEVEL, 32'h0000_000A);
        set(`ADDR_UV_DELAY, 32'h0000_0003);
        rd(`ADDR_UV_DELAY, rv, rr);
        chk(rv, 32'h0000_0003);
        for (int k = 0; k < 3; k++) begin
            sel <= 2'(k);
            drive(16'h0300, 16'h0200);
            tick(4);
            rd(`ADDR_MEAS, rv, rr);
            chk(rv, 32'h0200_0300);
        end
        sel <= 2'h1;
        foreach (rows[k]) begin
            set(`ADDR_CTRL, {24'h000000, rows[k][41:34]});
            drive(rows[k][17:2], rows[k][33:18]);
            tick(6);
            so = pick(rows[k][1]);
            chk({31'h0, so.start}, {31'h0, rows[k][0]});
        end
        set(`ADDR_CTRL, 32'h0000_0001);
        set(`ADDR_OC_DELAY, 32'h0000_0005);
        drive(16'h07D0, 16'h03E8);
        tick(20);
        drive(16'h0000, 16'h03E8);
        tick(6);
        chk({30'h0, oc_out}, 32'h0000_0000);
        drive(16'h07D0, 16'h03E8);
        timed(1'b0, 5);
        set(`ADDR_CTRL, 32'h0000_0011);
        set(`ADDR_TMULT, 32'h0000_0001);
        set(`ADDR_MIN_TIME, 32'h0000_0005);
        for (int d = 0; d < 3; d += 2) begin
            drive(16'h0000, 16'h03E8);
            set(`ADDR_OC_DELAY, 32'(d));
            tick(6);
            drive(16'h2710, 16'h03E8);
            timed(1'b0, 5 + d);
        end
        set(`ADDR_TMULT, 32'h0000_FFFF);
        tick(200);
        chk({30'h0, oc_out}, 32'h0000_0002);
        drive(16'h0000, 16'h01F4);
        set(`ADDR_CTRL, 32'h0000_0003);
        timed(1'b1, 3);
        drive(16'h0000, 16'h03E8);
        set(`ADDR_OC_DELAY, 32'h0000_03E8);
        set(`ADDR_CTRL, 32'h0000_0023);
        drive(16'h0000, 16'h01F4);
        tick(6);
        chk({30'h0, uv_out}, 32'h0000_0000);
        drive(16'h07D0, 16'h01F4);
        timed(1'b1, 3);
        chk({31'h0, seal_trip}, 32'h0000_0001);
        repeat (80) begin
            @(posedge aclk);
            if (!seal_trip && !oc_out.start && !uv_out.start) seen = 1'b1;
        end
        chk({31'h0, seen}, 32'h0000_0001);
        drive(16'h0000, 16'h03E8);
        tick(10);
        finish_test();
    end
endmodule
bind vroc_top vroc_top_monitor #(.TICK(TICK), .SEAL_MS(SEAL_MS)) u_mon (
    .aclk(aclk), .aresetn(aresetn), .phase_current(phase_current),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bvalid(s_bvalid), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rvalid(s_rvalid),
    .oc_out(oc_out), .uv_out(uv_out), .seal_trip(seal_trip));
`default_nettype wire
